/* File: rtl/ies_status_events.sv */
// Status event block: standard and operation event sets, service request
// enable and status byte, driven by decoded common commands.
// Assumes a command decoder on the same clock presents one command per
// cycle and takes a registered answer one cycle later.
`timescale 1ns/1ps
`include "ies_status_map.svh"

module ies_status_events #(
  parameter int DATA_W = 8
) (
  // Clock and reset; reset stands for power-on.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Command port.
  input  wire logic             cmd_valid,
  input  wire ies_pkg::ies_cmd_t cmd_code,
  input  wire logic [DATA_W-1:0] cmd_data,
  // Answer port.
  output logic                  rsp_valid,
  output logic [DATA_W-1:0]     rsp_data,
  // Device events and live status.
  input  wire logic             cmd_error_evt,
  input  wire logic             exec_error_evt,
  input  wire logic             query_error_evt,
  input  wire logic             ops_pending,
  input  wire logic [DATA_W-1:0] oper_cond,
  input  wire logic             msg_avail,
  // Status outputs.
  output logic [DATA_W-1:0]     status_byte,
  output logic                  master_summary
);
  import ies_pkg::*;

  if (DATA_W != `IES_REG_W) begin : g_bad_width
    $error("ies_status_events: DATA_W must be 8");
  end

  // Decoded strobes for this cycle.
  logic     ese_wr;
  logic     ope_wr;
  logic     sre_wr;
  logic     esr_rd;
  logic     opr_rd;
  logic     cls;
  logic     opc_arm;
  logic     bad_cmd;

  always_comb begin
    ese_wr  = 1'b0;
    ope_wr  = 1'b0;
    sre_wr  = 1'b0;
    esr_rd  = 1'b0;
    opr_rd  = 1'b0;
    cls     = 1'b0;
    opc_arm = 1'b0;
    bad_cmd = 1'b0;
    if (cmd_valid) begin
      case (cmd_code)
        IES_CMD_ESE_WR:  ese_wr  = 1'b1;                     // R1 R12
        IES_CMD_OPE_WR:  ope_wr  = 1'b1;                     // R1
        IES_CMD_SRE_WR:  sre_wr  = 1'b1;                     // R1
        IES_CMD_ESR_RD:  esr_rd  = 1'b1;                     // R13
        IES_CMD_OPR_RD:  opr_rd  = 1'b1;                     // R4
        IES_CMD_CLS:     cls     = 1'b1;                     // R5
        IES_CMD_OPC_ARM: opc_arm = 1'b1;
        IES_CMD_ESE_RD,
        IES_CMD_OPE_RD,
        IES_CMD_OPC_RD,
        IES_CMD_SRE_RD,
        IES_CMD_STB_RD:  bad_cmd = 1'b0;
        default:         bad_cmd = 1'b1;                     // R15
      endcase
    end
  end

  // Power-on flag is raised in the first cycle after reset release.
  logic pon_pend_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pon_pend_r <= 1'b1;
    end else begin
      pon_pend_r <= 1'b0;                                    // R14
    end
  end

  // Operation complete arms on the command and fires once idle.
  logic opc_armed_r;
  logic opc_done;

  assign opc_done = (opc_armed_r | opc_arm) & ~ops_pending;  // R18

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opc_armed_r <= 1'b0;
    end else if (opc_done) begin
      opc_armed_r <= 1'b0;
    end else if (opc_arm) begin
      opc_armed_r <= 1'b1;
    end
  end

  // Standard event sources mapped onto their fixed positions.
  ies_reg_t esr_set;

  always_comb begin
    esr_set                    = `IES_ZERO;
    esr_set[`IES_ESR_PON_BIT]  = pon_pend_r;                 // R14
    esr_set[`IES_ESR_CME_BIT]  = cmd_error_evt | bad_cmd;    // R15
    esr_set[`IES_ESR_EXE_BIT]  = exec_error_evt;             // R16
    esr_set[`IES_ESR_QYE_BIT]  = query_error_evt;            // R17
    esr_set[`IES_ESR_OPC_BIT]  = opc_done;                   // R18
  end

  // Operation events latch on a rising condition bit.
  ies_reg_t oper_cond_prev_r;
  ies_reg_t oper_set;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oper_cond_prev_r <= `IES_ZERO;
    end else begin
      oper_cond_prev_r <= oper_cond;
    end
  end

  assign oper_set = oper_cond & ~oper_cond_prev_r;

  // The two event sets of the status system.
  ies_reg_t esr_q;
  ies_reg_t ese_q;
  ies_reg_t oper_q;
  ies_reg_t ope_q;
  logic     esb_sum;
  logic     osb_sum;

  ies_event_set #(
    .WIDTH    (`IES_REG_W),
    .USED     (`IES_ESR_USED)
  ) u_std (                                                  // R10 R22
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_vec  (esr_set),
    .evt_clr  (esr_rd | cls),                                // R13 R5
    .ena_wr   (ese_wr),
    .ena_data (cmd_data),
    .evt_r    (esr_q),
    .ena_r    (ese_q),
    .summary  (esb_sum)
  );

  ies_event_set #(
    .WIDTH    (`IES_REG_W),
    .USED     (`IES_OPER_USED)
  ) u_oper (                                                 // R10
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_vec  (oper_set),
    .evt_clr  (opr_rd | cls),                                // R4 R5
    .ena_wr   (ope_wr),
    .ena_data (cmd_data),
    .evt_r    (oper_q),
    .ena_r    (ope_q),
    .summary  (osb_sum)
  );

  // Service request enable; the master summary position is not maskable.
  ies_reg_t sre_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sre_r <= `IES_ENA_RESET;                               // R7
    end else if (sre_wr) begin
      sre_r <= cmd_data & `IES_STB_MSS_MASK;                 // R2 R6
    end
  end

  // Status byte follows its sources and has no clear of its own.
  ies_reg_t stb_sum;
  ies_reg_t stb_r;

  always_comb begin
    stb_sum                   = `IES_ZERO;
    stb_sum[`IES_STB_OSB_BIT] = osb_sum;                     // R20
    stb_sum[`IES_STB_ESB_BIT] = esb_sum;                     // R9 R20
    stb_sum[`IES_STB_MAV_BIT] = msg_avail;
    stb_sum[`IES_STB_MSS_BIT] = |(stb_sum & sre_r);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stb_r <= `IES_STB_RESET;                               // R7
    end else begin
      stb_r <= stb_sum;                                      // R8
    end
  end

  assign status_byte    = stb_r;
  assign master_summary = stb_r[`IES_STB_MSS_BIT];

  // Query answers are the plain register bit patterns, bit 7 weighted 128.
  ies_reg_t rsp_nxt;
  logic     rsp_hit;

  always_comb begin
    rsp_nxt = `IES_ZERO;
    rsp_hit = 1'b0;
    if (cmd_valid) begin
      case (cmd_code)
        IES_CMD_ESE_RD: begin
          rsp_nxt = ese_q;                                   // R12
          rsp_hit = 1'b1;
        end
        IES_CMD_ESR_RD: begin
          rsp_nxt = esr_q;                                   // R13 R21
          rsp_hit = 1'b1;
        end
        IES_CMD_OPE_RD: begin
          rsp_nxt = ope_q;
          rsp_hit = 1'b1;
        end
        IES_CMD_OPR_RD: begin
          rsp_nxt = oper_q;                                  // R4
          rsp_hit = 1'b1;
        end
        IES_CMD_OPC_RD: begin
          rsp_nxt = oper_cond;                               // R3
          rsp_hit = 1'b1;
        end
        IES_CMD_SRE_RD: begin
          rsp_nxt = sre_r;
          rsp_hit = 1'b1;
        end
        IES_CMD_STB_RD: begin
          rsp_nxt = stb_r;
          rsp_hit = 1'b1;
        end
        default: begin
          rsp_nxt = `IES_ZERO;
          rsp_hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= `IES_ZERO;
    end else begin
      rsp_valid <= rsp_hit;
      if (rsp_hit) begin
        rsp_data <= rsp_nxt;                                 // R21
      end
    end
  end

endmodule

/* File: rtl/ies_status_map.svh */
// Register map, bit positions and reset values of the status event block.
// Assumes it is included by its bare name from the package and the modules.
// Operation
// R1 - Host may write only the enable registers.
// R2 - Controller sends one binary-weighted value per enable.
// R3 - Condition register follows live status, never latched.
// R4 - Event register query clears it after returning.
// R5 - Clear-status clears both event registers together.
// R6 - Writing zero clears any enable register.
// R7 - Power-on clears events, enables and status byte.
// R8 - Status byte bits drop only with sources.
// R9 - Event summary bit five clears after event query.
// R10 - Exactly two event sets: standard and operation.
// R11 - Standard bit counts only when its enable set.
// R12 - Enable load command; enable query leaves it unchanged.
// R13 - Standard event query returns contents, then clears.
// R14 - Power-on flag bit seven set after power-up.
// R15 - Command error flag bit five on bad command.
// R16 - Execution error flag bit four on impossible action.
// R17 - Query error flag bit two on lost output.
// R18 - Operation complete bit zero after pending work ends.
// R19 - Event bits latch until query or clear-status.
// R20 - Summary is OR of event AND enable.
// R21 - Query returns binary-weighted register value, bit seven 128.
// R22 - Unused standard bits one, three, six read zero.
`ifndef IES_STATUS_MAP_SVH
`define IES_STATUS_MAP_SVH

`define IES_REG_W          8
`define IES_ZERO           8'h00
`define IES_ESR_RESET      8'h00
`define IES_ENA_RESET      8'h00
`define IES_STB_RESET      8'h00
`define IES_ESR_USED       8'hB5
`define IES_OPER_USED      8'hFF
`define IES_ESR_OPC_BIT    0
`define IES_ESR_QYE_BIT    2
`define IES_ESR_EXE_BIT    4
`define IES_ESR_CME_BIT    5
`define IES_ESR_PON_BIT    7
`define IES_STB_MAV_BIT    4
`define IES_STB_ESB_BIT    5
`define IES_STB_MSS_BIT    6
`define IES_STB_OSB_BIT    7
`define IES_STB_MSS_MASK   8'hBF

`endif

/* File: rtl/ies_pkg.sv */
// Types shared by the status event block, its checker and the bench.
// Assumes ies_status_map.svh is on the include path.
`include "ies_status_map.svh"

package ies_pkg;

  typedef logic [`IES_REG_W-1:0] ies_reg_t;

  // Commands the bus controller can hand to the status block.
  typedef enum logic [3:0] {
    IES_CMD_ESE_WR,
    IES_CMD_ESE_RD,
    IES_CMD_ESR_RD,
    IES_CMD_OPE_WR,
    IES_CMD_OPE_RD,
    IES_CMD_OPR_RD,
    IES_CMD_OPC_RD,
    IES_CMD_SRE_WR,
    IES_CMD_SRE_RD,
    IES_CMD_STB_RD,
    IES_CMD_CLS,
    IES_CMD_OPC_ARM
  } ies_cmd_t;

endpackage

/* File: rtl/ies_event_set.sv */
// One event register set: latched event bits, enable mask and summary.
// Assumes set pulses and clear strobes come from logic on the same clock.
`timescale 1ns/1ps
`include "ies_status_map.svh"

module ies_event_set #(
  parameter int                WIDTH = 8,
  parameter logic [WIDTH-1:0]  USED  = '1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Event sources and clears.
  input  wire logic [WIDTH-1:0] set_vec,
  input  wire logic             evt_clr,
  // Enable register load.
  input  wire logic             ena_wr,
  input  wire logic [WIDTH-1:0] ena_data,
  // State seen by the parent.
  output logic      [WIDTH-1:0] evt_r,
  output logic      [WIDTH-1:0] ena_r,
  output logic                  summary
);

  // Refuses widths that do not fit one status register.
  if (WIDTH < 1 || WIDTH > `IES_REG_W) begin : g_bad_width
    $error("ies_event_set: WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] evt_nxt;

  // A set arriving in the clearing cycle survives the clear.
  always_comb begin
    evt_nxt = evt_clr ? '0 : evt_r;                          // R4 R5
    evt_nxt = (evt_nxt | set_vec) & USED;                    // R19 R22
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_r <= '0;                                           // R7
    end else begin
      evt_r <= evt_nxt;                                      // R19
    end
  end

  // The written pattern is loaded with the unused bits masked off, so a zero clears the mask.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ena_r <= '0;                                           // R7
    end else if (ena_wr) begin
      ena_r <= ena_data & USED;                              // R2 R6
    end
  end

  assign summary = |(evt_r & ena_r);                         // R20 R11

endmodule

/* File: tb/ies_sts_asserts.sv */
// Port checks for the status event block.
// Assumes ies_pkg is compiled first; bound to ies_status_events below.
`timescale 1ns/1ps

module ies_sts_asserts #(
  parameter int DATA_W = 8
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              sys_rst,
  // Command and answer.
  input wire logic              cmd_valid,
  input wire ies_pkg::ies_cmd_t cmd_code,
  input wire logic [DATA_W-1:0] cmd_data,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  // Events and status.
  input wire logic              cmd_error_evt,
  input wire logic              exec_error_evt,
  input wire logic              query_error_evt,
  input wire logic              ops_pending,
  input wire logic [DATA_W-1:0] oper_cond,
  input wire logic              msg_avail,
  input wire logic [DATA_W-1:0] status_byte,
  input wire logic              master_summary
);
  import ies_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic       rd;
  logic       quiet;
  logic [2:0] evs;
  assign rd = cmd_valid && cmd_code inside {IES_CMD_ESE_RD, IES_CMD_ESR_RD,
    IES_CMD_OPE_RD, IES_CMD_OPR_RD, IES_CMD_OPC_RD, IES_CMD_SRE_RD,
    IES_CMD_STB_RD};
  assign evs = {cmd_error_evt, exec_error_evt, query_error_evt};
  assign quiet = evs == 3'h0 && ops_pending;
  sequence s_esr_rd;
    cmd_valid && cmd_code == IES_CMD_ESR_RD;
  endsequence
  sequence s_ese_wr;
    cmd_valid && cmd_code == IES_CMD_ESE_WR;
  endsequence
  property p_rsp;
    rd |=> rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_rst;
    disable iff (1'b0) sys_rst |=> !rsp_valid && status_byte == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_cond;
    cmd_valid && cmd_code == IES_CMD_OPC_RD |=> rsp_data == $past(oper_cond);
  endproperty
  a_cond: assert property (p_cond) else $error("condition");
  property p_ese_rb;
    s_ese_wr ##1 cmd_valid && cmd_code == IES_CMD_ESE_RD
      |=> rsp_data == ($past(cmd_data, 2) & 8'hB5);
  endproperty
  a_ese_rb: assert property (p_ese_rb) else $error("enable readback");
  property p_err;
    s_esr_rd and !$past(sys_rst) |=> ($past(evs, 2)
      & ~{rsp_data[5], rsp_data[4], rsp_data[2]}) == 3'h0;
  endproperty
  a_err: assert property (p_err) else $error("event lost");
  property p_unused;
    s_esr_rd or (cmd_valid && cmd_code == IES_CMD_ESE_RD)
      |=> (rsp_data & 8'h4A) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit");
  property p_esr_clr;
    (s_esr_rd and quiet && !$past(sys_rst)) ##1 quiet && !cmd_valid
      |=> !status_byte[5];
  endproperty
  a_esr_clr: assert property (p_esr_clr) else $error("summary kept");
  property p_ese0;
    (s_ese_wr and cmd_data == 8'h00) ##1 !(cmd_valid
      && cmd_code == IES_CMD_ESE_WR) |=> !status_byte[5];
  endproperty
  a_ese0: assert property (p_ese0) else $error("zero enable");
  property p_opc;
    cmd_valid && cmd_code == IES_CMD_OPC_ARM && !ops_pending ##1 s_esr_rd
      |=> rsp_data[0];
  endproperty
  a_opc: assert property (p_opc) else $error("completion");
endmodule

bind ies_status_events ies_sts_asserts #(.DATA_W(DATA_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .cmd_error_evt(cmd_error_evt),
  .exec_error_evt(exec_error_evt), .query_error_evt(query_error_evt),
  .ops_pending(ops_pending), .oper_cond(oper_cond),
  .msg_avail(msg_avail), .status_byte(status_byte),
  .master_summary(master_summary));

/* File: tb/ies_ctl_model.sv */
// Bus controller model that hands decoded common commands to the block.
// Assumes the block takes a command at each rising edge with valid high.
`timescale 1ns/1ps

module ies_ctl_model (
  // Clock and answer.
  input  wire logic         clk,
  input  wire logic         rsp_valid,
  input  wire logic [7:0]   rsp_data,
  // Command drive.
  output logic              cmd_valid,
  output ies_pkg::ies_cmd_t cmd_code,
  output logic [7:0]        cmd_data
);
  import ies_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = IES_CMD_STB_RD;
    cmd_data = 8'h00;
  end
  task automatic issue(input ies_cmd_t c, input logic [7:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(posedge clk);
  endtask
  // Releases the port and inverts the data so no stale value lingers.
  task automatic idle(output logic v, output logic [7:0] d);
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_data = ~cmd_data;
    v = rsp_valid;
    d = rsp_data;
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the status event block.
// Assumes ies_ctl_model drives the command port and the checker is bound.
`timescale 1ns/1ps

module tb_top;
  import ies_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [2:0] ev = 3'h0;
  logic       ops_pending = 1'b1;
  logic [7:0] oper_cond = 8'h00;
  logic       msg_avail = 1'b0;
  logic       cmd_valid;
  ies_cmd_t   cmd_code;
  logic [7:0] cmd_data;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic [7:0] status_byte;
  logic       master_summary;
  int         errors = 0;
  int         cmp_count = 0;
  ies_cmd_t   wc[3] = '{IES_CMD_ESE_WR, IES_CMD_OPE_WR, IES_CMD_SRE_WR};
  ies_cmd_t   rc[3] = '{IES_CMD_ESE_RD, IES_CMD_OPE_RD, IES_CMD_SRE_RD};
  logic [7:0] um[3] = '{8'hB5, 8'hFF, 8'hBF};

  always #12.5 clk = ~clk;

  ies_ctl_model ctl (.clk(clk), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data));
  ies_status_events #(.DATA_W(8)) uut (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_error_evt(ev[2]),
    .exec_error_evt(ev[1]), .query_error_evt(ev[0]),
    .ops_pending(ops_pending), .oper_cond(oper_cond),
    .msg_avail(msg_avail), .status_byte(status_byte),
    .master_summary(master_summary));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input ies_cmd_t c, input logic [7:0] exp);
    logic       v;
    logic [7:0] d;
    ctl.issue(c, 8'h00);
    ctl.idle(v, d);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  task automatic wr(input ies_cmd_t c, input logic [7:0] d);
    logic       v;
    logic [7:0] q;
    ctl.issue(c, d);
    ctl.idle(v, q);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = 3'h0;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    errors++;
    results();
  end

  initial begin
    wt(20);
    sys_rst = 1'b0;
    wt(3);
    rd(IES_CMD_ESE_RD, 8'h00);
    rd(IES_CMD_STB_RD, 8'h00);
    rd(IES_CMD_ESR_RD, 8'h80);
    rd(IES_CMD_ESR_RD, 8'h00);
    $display("test power_on done");
    foreach (wc[i]) begin
      ctl.issue(wc[i], 8'hFF);
      rd(rc[i], um[i]);
      rd(rc[i], um[i]);
      ctl.issue(wc[i], 8'h00);
      rd(rc[i], 8'h00);
    end
    $display("test enables done");
    wr(IES_CMD_ESE_WR, 8'h20);
    pulse(3'h3);
    wt(3);
    chk(status_byte, 8'h00);
    pulse(3'h4);
    pulse(3'h4);
    wt(3);
    chk(status_byte, 8'h20);
    rd(IES_CMD_ESR_RD, 8'h34);
    wt(3);
    chk(status_byte, 8'h00);
    ctl.issue(ies_cmd_t'(4'hC), 8'h00);
    rd(IES_CMD_ESR_RD, 8'h20);
    $display("test errors done");
    wr(IES_CMD_OPC_ARM, 8'h00);
    wt(3);
    rd(IES_CMD_ESR_RD, 8'h00);
    ops_pending = 1'b0;
    wt(2);
    rd(IES_CMD_ESR_RD, 8'h01);
    ctl.issue(IES_CMD_OPC_ARM, 8'h00);
    rd(IES_CMD_ESR_RD, 8'h01);
    wr(IES_CMD_OPE_WR, 8'h01);
    oper_cond = 8'h5A;
    rd(IES_CMD_OPC_RD, 8'h5A);
    oper_cond = 8'h0F;
    rd(IES_CMD_OPC_RD, 8'h0F);
    wt(2);
    chk(status_byte, 8'h80);
    rd(IES_CMD_OPR_RD, 8'h5F);
    rd(IES_CMD_OPR_RD, 8'h00);
    $display("test operation done");
    wr(IES_CMD_SRE_WR, 8'h20);
    pulse(3'h4);
    oper_cond = 8'hFF;
    wt(3);
    chk(status_byte, 8'h60);
    chk({7'h00, master_summary}, 8'h01);
    rd(IES_CMD_STB_RD, 8'h60);
    wr(IES_CMD_CLS, 8'h00);
    wt(2);
    chk(status_byte, 8'h00);
    chk({7'h00, master_summary}, 8'h00);
    rd(IES_CMD_ESR_RD, 8'h00);
    rd(IES_CMD_OPR_RD, 8'h00);
    msg_avail = 1'b1;
    wt(3);
    chk(status_byte, 8'h10);
    $display("test clear done");
    sys_rst = 1'b1;
    wt(2);
    chk(status_byte, 8'h00);
    sys_rst = 1'b0;
    wt(3);
    rd(IES_CMD_SRE_RD, 8'h00);
    rd(IES_CMD_ESR_RD, 8'h80);
    $display("test reset done");
    results();
  end
endmodule
